// ===== hw/fslp_access_check.v
`timescale 1ns/10ps
`include "fslp_regs.vh"

module fslp_access_check #(
	parameter AW = 12,
	parameter BOOT_AW = 9
) (
	// Request
	input wire [AW-1:0] addr,
	input wire [2:0] op,
	input wire [2:0] space,
	input wire from_pdp,
	input wire exec_boot,
	// Current protection
	input wire [7:0] lock,
	// Verdict
	output reg allow
);

	wire [AW-BOOT_AW-1:0] blk = addr[AW-1:BOOT_AW];
	reg [1:0] fld;

	// Boot is the top block, the table the block just below it, same size [R4]
	always @* begin
		if (&blk)
			fld = lock[`FSLP_LK_BOOT_LSB+1:`FSLP_LK_BOOT_LSB]; // [R5]
		else if (blk == {{(AW-BOOT_AW-1){1'b1}}, 1'b0})
			fld = lock[`FSLP_LK_TBL_LSB+1:`FSLP_LK_TBL_LSB]; // [R5]
		else
			fld = lock[`FSLP_LK_APP_LSB+1:`FSLP_LK_APP_LSB]; // [R5]
	end

	always @* begin
		allow = 1'b0;
		case (op)
		`FSLP_OP_READ: begin
			if (space == `FSLP_SP_FLASH)
				allow = fld[`FSLP_LK_RD]; // [R6] [R17]
			else
				allow = (space <= `FSLP_SP_LOCK); // [R7] [R10] [R12]
		end
		`FSLP_OP_WRITE, `FSLP_OP_ERPG: begin
			case (space)
			// Software may only store from the boot section, to any address [R1] [R2]
			`FSLP_SP_FLASH: allow = fld[`FSLP_LK_WR] & (from_pdp | exec_boot); // [R6] [R17]
			`FSLP_SP_USIG: allow = 1'b1; // [R10] [R11]
			default: allow = 1'b0; // [R7]
			endcase
		end
		// Chip erase names the flash space only, so it never targets a signature row
		`FSLP_OP_CHIP: allow = from_pdp & (space == `FSLP_SP_FLASH); // [R7]
		`FSLP_OP_LOCKW: allow = (space == `FSLP_SP_LOCK); // [R13]
		`FSLP_OP_FUSEW: allow = from_pdp & (space == `FSLP_SP_FUSE); // [R12]
		default: allow = 1'b0;
		endcase
	end

endmodule // fslp_access_check

// ===== hw/fslp_top.v
// Notes on behaviour
// (R1) Software flash writes are carried out only while executing from boot section.
// (R2) Stores from boot section may target any flash word, boot included, per locks.
// (R3) Program flash words are sixteen bits; instructions take one or two words.
// (R4) Application table sits inside application section, same size as boot section.
// (R5) Application, table and boot sections each have their own lock field.
// (R6) Each lock field can block reads, writes, or both for its section.
// (R7) Production row refuses writes and erases but reads from both sides.
// (R8) Selected calibration words are copied out at reset; software loads the rest.
// (R9) Production row holds device type and serial from lot, wafer and coordinates.
// (R10) User row is one page, read and written by software and programmer.
// (R11) Chip erase leaves the user row; only its own erase clears it.
// (R12) Fuses are written only by the programmer; software may only read them.
// (R13) Lock writes from either side can only tighten protection.
// (R14) Only chip erase returns lock bits to unprogrammed; here reset also reloads them to FSLP_LOCK_RST.
// (R15) Chip erase clears lock bits only after all flash words are erased.
// (R16) Unprogrammed fuse or lock bits read one, programmed ones read zero.
// (R17) Flash is read and written by the programmer port and by software.
// (R18) Fuses and lock bits can be reprogrammed, not one-time.
// (R19) Locks are checked on every access, so tightening acts from the next one.
`timescale 1ns/10ps
`include "fslp_regs.vh"

module fslp_top #(
	parameter AW = 12,
	parameter BOOT_AW = 9,
	parameter PAGE_AW = 5,
	parameter CAL_AUTO = 4,
	parameter [15:0] DEV_ID = 16'h5a01,
	parameter [15:0] LOT_NUM = 16'h1234,
	parameter [7:0] WAFER_NUM = 8'h07,
	parameter [7:0] COORD_X = 8'h10,
	parameter [7:0] COORD_Y = 8'h20,
	parameter [15:0] CAL_SEED = 16'h3c00
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Register port
	input wire [2:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire reg_we,
	input wire reg_re,
	output reg [15:0] reg_rdata,
	// Processor context
	input wire cpu_exec_boot,
	// Programmer port
	input wire pdp_strobe,
	input wire [2:0] pdp_op,
	input wire [2:0] pdp_space,
	input wire [AW-1:0] pdp_addr,
	input wire [15:0] pdp_wdata,
	output reg [15:0] pdp_rdata,
	output reg pdp_done,
	output reg pdp_denied,
	// Calibration load
	output reg cal_valid,
	output reg [3:0] cal_index,
	output reg [15:0] cal_data,
	// Live protection
	output reg [7:0] lock_bits
);

	// DEV_ID is arbitrary
	localparam DEPTH = 1 << AW;
	localparam PAGE = 1 << PAGE_AW;
	localparam FUSE_N = 8;
	localparam [1:0] S_CAL = 2'd0;
	localparam [1:0] S_IDLE = 2'd1;
	localparam [1:0] S_WALK = 2'd2;
	localparam [1:0] S_LOCKCLR = 2'd3;

	reg [1:0] rst_s_r;
	wire rst_n = rst_s_r[1];

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_s_r <= 2'b00;
		else
			rst_s_r <= {rst_s_r[0], 1'b1};
	end

	// Storage; flash and user row keep no reset, as nonvolatile cells
	reg [15:0] flash_mem [0:DEPTH-1];
	reg [15:0] usig_mem [0:PAGE-1];
	reg [7:0] fuse_r [0:FUSE_N-1];

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [AW-1:0] addr_r;
	reg [15:0] wdata_r;
	reg [15:0] result_r;
	reg denied_r;
	reg done_r;
	reg caldone_r;
	reg [AW-1:0] walk_ptr_r;
	reg [AW-1:0] walk_end_r;
	reg walk_usig_r;
	reg walk_chip_r;
	reg walk_pdp_r;
	reg [3:0] cal_ptr_r;

	function [15:0] prod_word;
		input [3:0] i;
		begin
			case (i)
			4'h0: prod_word = DEV_ID; // [R9]
			4'h1: prod_word = LOT_NUM; // [R9]
			4'h2: prod_word = {8'h00, WAFER_NUM}; // [R9]
			4'h3: prod_word = {COORD_X, COORD_Y}; // [R9]
			default: prod_word = CAL_SEED ^ {12'h000, i};
			endcase
		end
	endfunction

	// Request selection; the programmer wins a same-cycle clash
	wire idle = (state_r == S_IDLE);
	wire sw_cmd = reg_we && (reg_addr == `FSLP_ADR_CMD);
	wire pdp_go = pdp_strobe && idle;
	wire sw_go = sw_cmd && idle && !pdp_strobe;
	wire go = pdp_go | sw_go;
	wire [2:0] rq_op = pdp_go ? pdp_op : reg_wdata[`FSLP_CMD_OP_LSB+2:`FSLP_CMD_OP_LSB];
	wire [2:0] rq_sp = pdp_go ? pdp_space : reg_wdata[`FSLP_CMD_SP_LSB+2:`FSLP_CMD_SP_LSB];
	wire [AW-1:0] rq_addr = pdp_go ? pdp_addr : addr_r;
	wire [15:0] rq_wd = pdp_go ? pdp_wdata : wdata_r;
	wire allow;

	// Verdict uses the lock register as it stands now [R19]
	fslp_access_check #(
		.AW(AW),
		.BOOT_AW(BOOT_AW)
	) u_check (
		.addr(rq_addr),
		.op(rq_op),
		.space(rq_sp),
		.from_pdp(pdp_go),
		.exec_boot(cpu_exec_boot),
		.lock(lock_bits),
		.allow(allow)
	);

	wire ok = go && allow;
	wire is_walk = (rq_op == `FSLP_OP_ERPG) || (rq_op == `FSLP_OP_CHIP);
	wire single_done = ok && !is_walk;
	wire walk_last = (state_r == S_WALK) && (walk_ptr_r == walk_end_r);
	wire finish = (walk_last && !walk_chip_r) || (state_r == S_LOCKCLR);

	reg [15:0] rd_word;

	always @* begin
		case (rq_sp)
		`FSLP_SP_FLASH: rd_word = flash_mem[rq_addr]; // [R3] [R17]
		`FSLP_SP_USIG: rd_word = usig_mem[rq_addr[PAGE_AW-1:0]]; // [R10]
		`FSLP_SP_PROD: rd_word = prod_word(rq_addr[3:0]); // [R7]
		`FSLP_SP_FUSE: rd_word = {8'h00, fuse_r[rq_addr[2:0]]}; // [R12] [R16]
		`FSLP_SP_LOCK: rd_word = {8'h00, lock_bits}; // [R16]
		default: rd_word = 16'h0000;
		endcase
	end

	// Memory write port
	reg fl_we;
	reg us_we;
	reg [AW-1:0] mem_addr;
	reg [15:0] mem_wd;

	always @* begin
		fl_we = 1'b0;
		us_we = 1'b0;
		mem_addr = rq_addr;
		mem_wd = rq_wd;
		if (state_r == S_WALK) begin
			mem_addr = walk_ptr_r;
			mem_wd = `FSLP_ERASED;
			fl_we = !walk_usig_r; // [R15]
			us_we = walk_usig_r; // [R11]
		end else if (ok && rq_op == `FSLP_OP_WRITE) begin
			fl_we = (rq_sp == `FSLP_SP_FLASH); // [R1] [R2] [R17]
			us_we = (rq_sp == `FSLP_SP_USIG); // [R10]
		end
	end

	always @(posedge clk) begin
		if (fl_we)
			flash_mem[mem_addr] <= mem_wd;
		if (us_we)
			usig_mem[mem_addr[PAGE_AW-1:0]] <= mem_wd;
	end

	// Fuses: any value may be written, in either direction
	wire fuse_we = ok && (rq_op == `FSLP_OP_FUSEW);
	wire [FUSE_N-1:0] fuse_sel = fuse_we ? ({{(FUSE_N-1){1'b0}}, 1'b1} << rq_addr[2:0]) :
		{FUSE_N{1'b0}};

	genvar g;
	generate
		for (g = 0; g < FUSE_N; g = g + 1) begin : g_fuse
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					fuse_r[g] <= `FSLP_FUSE_RST; // [R16]
				else if (fuse_sel[g])
					fuse_r[g] <= rq_wd[7:0]; // [R12] [R18]
			end
		end
	endgenerate

	// Sequencer
	always @* begin
		state_nxt = state_r;
		case (state_r)
		S_CAL: begin
			if (cal_ptr_r == CAL_AUTO - 1)
				state_nxt = S_IDLE;
		end
		S_IDLE: begin
			if (ok && is_walk)
				state_nxt = S_WALK;
		end
		S_WALK: begin
			if (walk_last)
				state_nxt = walk_chip_r ? S_LOCKCLR : S_IDLE; // [R15]
		end
		S_LOCKCLR: state_nxt = S_IDLE;
		default: state_nxt = S_IDLE;
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= S_CAL;
			walk_ptr_r <= {AW{1'b0}};
			walk_end_r <= {AW{1'b0}};
			walk_usig_r <= 1'b0;
			walk_chip_r <= 1'b0;
			walk_pdp_r <= 1'b0;
			lock_bits <= `FSLP_LOCK_RST; // [R16]
		end else begin
			state_r <= state_nxt;
			if (state_r == S_WALK)
				walk_ptr_r <= walk_ptr_r + {{(AW-1){1'b0}}, 1'b1};
			if (ok && rq_op == `FSLP_OP_CHIP) begin
				walk_ptr_r <= {AW{1'b0}};
				walk_end_r <= {AW{1'b1}};
				walk_usig_r <= 1'b0; // [R11]
				walk_chip_r <= 1'b1;
				walk_pdp_r <= pdp_go;
			end else if (ok && rq_op == `FSLP_OP_ERPG) begin
				walk_ptr_r <= {rq_addr[AW-1:PAGE_AW], {PAGE_AW{1'b0}}};
				walk_end_r <= {rq_addr[AW-1:PAGE_AW], {PAGE_AW{1'b1}}};
				walk_usig_r <= (rq_sp == `FSLP_SP_USIG); // [R11]
				walk_chip_r <= 1'b0;
				walk_pdp_r <= pdp_go;
			end
			// Outside reset, locks loosen only here, after the last flash word is erased
			if (state_r == S_LOCKCLR)
				lock_bits <= `FSLP_LOCK_RST; // [R14] [R15]
			else if (ok && rq_op == `FSLP_OP_LOCKW)
				lock_bits <= lock_bits & rq_wd[7:0]; // [R13] [R18]
		end
	end

	// Calibration copy straight after reset release
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cal_ptr_r <= 4'h0;
			cal_valid <= 1'b0;
			cal_index <= 4'h0;
			cal_data <= 16'h0000;
			caldone_r <= 1'b0;
		end else begin
			cal_valid <= (state_r == S_CAL); // [R8]
			if (state_r == S_CAL) begin
				cal_index <= cal_ptr_r;
				cal_data <= prod_word(`FSLP_PROD_CAL_FIRST + cal_ptr_r); // [R8]
				cal_ptr_r <= cal_ptr_r + 4'h1;
			end
			if (state_r == S_CAL && state_nxt == S_IDLE)
				caldone_r <= 1'b1;
		end
	end

	// Programmer answers, one cycle after the strobe, the page walk end or the chip erase lock clear
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pdp_rdata <= 16'h0000;
			pdp_done <= 1'b0;
			pdp_denied <= 1'b0;
		end else begin
			pdp_done <= (pdp_go && single_done) || (finish && walk_pdp_r); // [R17]
			pdp_denied <= pdp_strobe && !(pdp_go && allow);
			if (pdp_go && allow && rq_op == `FSLP_OP_READ)
				pdp_rdata <= rd_word; // [R17]
		end
	end

	// Register port
	wire st_w1c = reg_we && (reg_addr == `FSLP_ADR_STATUS);
	wire sw_refused = sw_cmd && !(sw_go && allow);
	wire sw_fin = (sw_go && single_done) || (finish && !walk_pdp_r);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= {AW{1'b0}};
			wdata_r <= 16'h0000;
			result_r <= 16'h0000;
			denied_r <= 1'b0;
			done_r <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			if (reg_we && reg_addr == `FSLP_ADR_ADDR)
				addr_r <= reg_wdata[AW-1:0];
			if (reg_we && reg_addr == `FSLP_ADR_WDATA)
				wdata_r <= reg_wdata;
			if (sw_go && allow && rq_op == `FSLP_OP_READ)
				result_r <= rd_word; // [R12] [R17]
			// A new event wins over a clear in the same cycle
			if (sw_refused)
				denied_r <= 1'b1; // [R1] [R7] [R12]
			else if (st_w1c && reg_wdata[`FSLP_ST_DENIED])
				denied_r <= 1'b0;
			if (sw_fin)
				done_r <= 1'b1;
			else if (st_w1c && reg_wdata[`FSLP_ST_DONE])
				done_r <= 1'b0;
			reg_rdata <= 16'h0000;
			if (reg_re) begin
				case (reg_addr)
				`FSLP_ADR_ADDR: reg_rdata <= {{(16-AW){1'b0}}, addr_r};
				`FSLP_ADR_WDATA: reg_rdata <= wdata_r;
				`FSLP_ADR_STATUS: reg_rdata <= {12'h000, caldone_r, done_r, denied_r, !idle};
				`FSLP_ADR_RESULT: reg_rdata <= result_r;
				`FSLP_ADR_LOCK: reg_rdata <= {8'h00, lock_bits}; // [R16]
				default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

endmodule // fslp_top

// ===== include/fslp_regs.vh
`ifndef FSLP_REGS_VH
`define FSLP_REGS_VH

// Register word indices on the register port
`define FSLP_ADR_ADDR 3'h0
`define FSLP_ADR_WDATA 3'h1
`define FSLP_ADR_CMD 3'h2
`define FSLP_ADR_STATUS 3'h3
`define FSLP_ADR_RESULT 3'h4
`define FSLP_ADR_LOCK 3'h5

// Command word fields
`define FSLP_CMD_OP_LSB 0
`define FSLP_CMD_SP_LSB 4

// Operations
`define FSLP_OP_READ 3'h1
`define FSLP_OP_WRITE 3'h2
`define FSLP_OP_ERPG 3'h3
`define FSLP_OP_CHIP 3'h4
`define FSLP_OP_LOCKW 3'h5
`define FSLP_OP_FUSEW 3'h6

// Memory spaces
`define FSLP_SP_FLASH 3'h0
`define FSLP_SP_USIG 3'h1
`define FSLP_SP_PROD 3'h2
`define FSLP_SP_FUSE 3'h3
`define FSLP_SP_LOCK 3'h4

// Status bits
`define FSLP_ST_BUSY 0
`define FSLP_ST_DENIED 1
`define FSLP_ST_DONE 2
`define FSLP_ST_CALDONE 3

// Lock byte layout: two bits per section, write block then read block
`define FSLP_LK_APP_LSB 0
`define FSLP_LK_TBL_LSB 2
`define FSLP_LK_BOOT_LSB 4
`define FSLP_LK_WR 0
`define FSLP_LK_RD 1

// Reset and erased values
`define FSLP_LOCK_RST 8'hff
`define FSLP_FUSE_RST 8'hff
`define FSLP_ERASED 16'hffff

// Production row layout
`define FSLP_PROD_CAL_FIRST 4'h4

`endif

// ===== verification/fslp_prog_model.sv
`timescale 1ns/10ps
module fslp_prog_model #(
	parameter AW = 6
) (
	// Clock
	input wire clk,
	// Requests to the device
	output reg pdp_strobe,
	output reg [2:0] pdp_op,
	output reg [2:0] pdp_space,
	output reg [AW-1:0] pdp_addr,
	output reg [15:0] pdp_wdata,
	// Answers from the device
	input wire [15:0] pdp_rdata,
	input wire pdp_done,
	input wire pdp_denied
);
	reg ok;
	reg [15:0] data;
	integer n;
	initial begin
		pdp_strobe = 1'b0;
		pdp_op = 3'h0;
		pdp_space = 3'h0;
		pdp_addr = {AW{1'b0}};
		pdp_wdata = 16'h0;
	end
	// One request at a time, fields held up to the taking edge
	task req(input [2:0] op, input [2:0] sp, input [AW-1:0] a, input [15:0] d, input integer gap);
		begin
			repeat (gap) @(posedge clk);
			@(posedge clk);
			pdp_strobe <= 1'b1;
			pdp_op <= op;
			pdp_space <= sp;
			pdp_addr <= a;
			pdp_wdata <= d;
			@(posedge clk);
			pdp_strobe <= 1'b0;
			// Released data shows the inverse so a stale copy cannot pass
			pdp_wdata <= ~d;
			n = 0;
			@(negedge clk);
			// Chip erase walks the whole array, hence the wide bound
			while (!pdp_done && !pdp_denied && n < 200) begin
				@(negedge clk);
				n = n + 1;
			end
			ok = pdp_done;
			data = pdp_rdata;
		end
	endtask
endmodule // fslp_prog_model

// ===== verification/fslp_properties.sv
`timescale 1ns/10ps
`include "fslp_regs.vh"
module fslp_properties #(
	parameter AW = 12,
	parameter BOOT_AW = 9,
	parameter CAL_AUTO = 4,
	parameter [15:0] CAL_SEED = 16'h3c00
) (
	// Clock and reset
	input wire clk,
	input wire arst_n,
	// Programmer port
	input wire pdp_strobe,
	input wire [2:0] pdp_op,
	input wire [2:0] pdp_space,
	input wire [AW-1:0] pdp_addr,
	input wire [15:0] pdp_wdata,
	input wire pdp_done,
	input wire pdp_denied,
	// Calibration and protection
	input wire cal_valid,
	input wire [3:0] cal_index,
	input wire [15:0] cal_data,
	input wire [7:0] lock_bits
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	reg erase_r;
	wire boot_hit = &pdp_addr[AW-1:BOOT_AW];
	// Remembers a running chip erase so loosened locks can be traced to it
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			erase_r <= 1'b0;
		else if (pdp_done || pdp_denied)
			erase_r <= 1'b0;
		else if (pdp_strobe && pdp_op == `FSLP_OP_CHIP)
			erase_r <= 1'b1;
	end
	sequence lock_up;
		|(lock_bits & ~$past(lock_bits));
	endsequence
	sequence erase_end;
		erase_r ##[0:1] pdp_done;
	endsequence
	lock_order_a: assert property (lock_up |-> erase_end)
		else $error("lock loosened outside erase end");
	lock_and_a: assert property (pdp_strobe && pdp_op == `FSLP_OP_LOCKW |=> pdp_denied ||
		lock_bits == ($past(lock_bits) & $past(pdp_wdata[7:0]))) else $error("lock not anded");
	prod_ro_a: assert property (pdp_strobe && pdp_space == `FSLP_SP_PROD &&
		pdp_op != `FSLP_OP_READ |=> pdp_denied && !pdp_done) else $error("prod row changed");
	boot_read_a: assert property (pdp_strobe && pdp_op == `FSLP_OP_READ && boot_hit &&
		pdp_space == `FSLP_SP_FLASH && !lock_bits[5] |=> pdp_denied) else $error("read lock");
	single_answer_a: assert property (pdp_strobe && pdp_op != `FSLP_OP_CHIP &&
		pdp_op != `FSLP_OP_ERPG |=> pdp_done != pdp_denied) else $error("no single answer");
	row_erase_a: assert property (pdp_strobe && pdp_op == `FSLP_OP_ERPG &&
		pdp_space == `FSLP_SP_USIG |-> ##[1:6] (pdp_done || pdp_denied)) else $error("slow erase");
	cal_step_a: assert property (cal_valid && cal_index < CAL_AUTO - 1 |=> cal_valid &&
		cal_index == $past(cal_index) + 4'h1) else $error("cal sequence broken");
	cal_data_a: assert property (cal_valid |-> cal_index < CAL_AUTO &&
		cal_data == (CAL_SEED ^ (`FSLP_PROD_CAL_FIRST + cal_index))) else $error("cal data");
endmodule // fslp_properties
bind fslp_top fslp_properties #(.AW(AW), .BOOT_AW(BOOT_AW), .CAL_AUTO(CAL_AUTO),
	.CAL_SEED(CAL_SEED)) u_props (.clk, .arst_n, .pdp_strobe, .pdp_op, .pdp_space,
	.pdp_addr, .pdp_wdata, .pdp_done, .pdp_denied, .cal_valid, .cal_index, .cal_data,
	.lock_bits);

// ===== verification/fslp_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
	$display("BAD %0t got %h want %h", $time, a, e); end end
module fslp_tb_top;
	reg clk = 1'b0;
	reg arst_n = 1'b0;
	reg [2:0] reg_addr = 3'h0;
	reg [15:0] reg_wdata = 16'h0;
	reg reg_we = 1'b0;
	reg reg_re = 1'b0;
	reg cpu_exec_boot = 1'b0;
	reg [15:0] rd;
	integer fail_count = 0;
	integer checks_done = 0;
	wire pdp_strobe, pdp_done, pdp_denied, cal_valid;
	wire [2:0] pdp_op, pdp_space;
	wire [5:0] pdp_addr;
	wire [15:0] pdp_wdata, pdp_rdata, reg_rdata, cal_data;
	wire [3:0] cal_index;
	wire [7:0] lock_bits;
	initial forever #2.5 clk = ~clk;
	// Small array keeps chip erase short; the identity value is arbitrary
	fslp_top #(.AW(6), .BOOT_AW(3), .PAGE_AW(2), .DEV_ID(16'h0abc))
		dut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
		.reg_rdata, .cpu_exec_boot, .pdp_strobe, .pdp_op, .pdp_space, .pdp_addr, .pdp_wdata,
		.pdp_rdata, .pdp_done, .pdp_denied, .cal_valid, .cal_index, .cal_data, .lock_bits);
	fslp_prog_model #(.AW(6)) u_prog (.clk, .pdp_strobe, .pdp_op, .pdp_space, .pdp_addr,
		.pdp_wdata, .pdp_rdata, .pdp_done, .pdp_denied);
	task wr(input [2:0] a, input [15:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_we <= 1'b1;
			@(posedge clk);
			reg_we <= 1'b0;
		end
	endtask
	task rdr(input [2:0] a);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_re <= 1'b1;
			@(posedge clk);
			reg_re <= 1'b0;
			@(negedge clk);
			rd = reg_rdata;
		end
	endtask
	// Software command: clear sticky flags first so the status is this command's own
	task sw(input [2:0] op, input [2:0] sp, input [5:0] a, input [15:0] d, input [15:0] st,
		input [15:0] x);
		begin
			wr(3'h0, {10'h0, a});
			wr(3'h1, d);
			wr(3'h3, 16'h0006);
			wr(3'h2, {9'h0, sp, 1'b0, op});
			repeat (2) @(posedge clk);
			rdr(3'h3);
			`CHK(rd & 16'h0007, st)
			if (op == 3'h1) begin
				rdr(3'h4);
				`CHK(rd, x)
			end
		end
	endtask
	// Programmer request; the idle gap cycles through zero, one and two clocks
	task pg(input [2:0] op, input [2:0] sp, input [5:0] a, input [15:0] d, input e,
		input [15:0] x);
		begin
			u_prog.req(op, sp, a, d, checks_done % 3);
			`CHK(u_prog.ok, e)
			if (op == 3'h1 && e)
				`CHK(u_prog.data, x)
		end
	endtask
	task conclude;
		begin
			if (fail_count == 0 && checks_done > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge clk);
		`CHK(lock_bits, 8'hff)
		rdr(3'h3);
		`CHK(rd, 16'h0008)
		pg(1, 2, 0, 0, 1, 16'h0abc);
		pg(2, 2, 1, 0, 0, 0);
		pg(3, 2, 0, 0, 0, 0);
		sw(1, 2, 5, 0, 4, 16'h3c05);
		sw(2, 0, 5, 16'h1111, 2, 0);
		@(posedge clk);
		cpu_exec_boot <= 1'b1;
		sw(2, 0, 60, 16'h2222, 4, 0);
		pg(1, 0, 60, 0, 1, 16'h2222);
		pg(2, 0, 6, 16'h4444, 1, 0);
		sw(1, 0, 6, 0, 4, 16'h4444);
		sw(6, 3, 1, 16'h00a5, 2, 0);
		pg(6, 3, 1, 16'h00a5, 1, 0);
		sw(1, 3, 1, 0, 4, 16'h00a5);
		pg(6, 3, 1, 16'h00ff, 1, 0);
		pg(1, 3, 1, 0, 1, 16'h00ff);
		sw(2, 1, 3, 16'h5555, 4, 0);
		pg(1, 1, 3, 0, 1, 16'h5555);
		sw(5, 4, 0, 16'h00fe, 4, 0);
		pg(5, 4, 0, 16'h00ff, 1, 0);
		`CHK(lock_bits, 8'hfe)
		sw(2, 0, 47, 16'h6666, 2, 0);
		sw(2, 0, 48, 16'h7777, 4, 0);
		pg(5, 4, 0, 16'h00db, 1, 0);
		sw(2, 0, 55, 16'h8888, 2, 0);
		sw(2, 0, 56, 16'h9999, 4, 0);
		pg(1, 0, 56, 0, 0, 0);
		sw(1, 0, 56, 0, 2, 16'h00a5);
		rdr(3'h5);
		`CHK(rd, 16'h00da)
		pg(4, 0, 0, 0, 1, 0);
		`CHK(lock_bits, 8'hff)
		pg(1, 0, 5, 0, 1, 16'hffff);
		pg(1, 1, 3, 0, 1, 16'h5555);
		pg(3, 1, 0, 0, 1, 0);
		pg(1, 1, 3, 0, 1, 16'hffff);
		sw(2, 1, 2, 16'h1234, 4, 0);
		// Software row erase is still walking when the status is first read
		sw(3, 1, 0, 0, 1, 0);
		rdr(3'h3);
		`CHK(rd & 16'h0007, 16'h0004)
		pg(1, 1, 2, 0, 1, 16'hffff);
		conclude;
	end
	// The sequence needs about 350 cycles; this allows about forty times that
	initial begin
		#75000;
		fail_count++;
		conclude;
	end
endmodule // fslp_tb_top
